// ===== include/sram_host_pkg.sv
// Purpose: shared constants for the static memory host controller
// Assumes: 20 MHz clock, 50 ns period
// Notes:   times in ns, cycle counts derived from them
package sram_host_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int CYCLE_TIME_NS  = 45;   // least read or write cycle time
    localparam int WRITE_PULSE_NS = 35;   // least write strobe width
    localparam int HZ_WE_NS       = 18;   // longest strobe-to-float time
    localparam int DATA_SETUP_NS  = 25;   // least data setup to write end
    localparam int ACCESS_NS      = 45;   // longest address to data valid

    // access, float and setup times round up, at least one cycle
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WFLOAT_CYC = (HZ_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WSETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W      = 4;

    // ----------------------------------------
    // pin levels after reset
    // ----------------------------------------
    localparam logic RST_SEL_N = 1'b1;
    localparam logic RST_SEL_P = 1'b0;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_ACCESS,
        ST_WR_FLOAT,
        ST_WR_DRIVE,
        ST_WR_END
    } seq_state_t;

endpackage : sram_host_pkg

// ===== rtl/lane_driver.sv
// Purpose: one byte lane of the data bus, drive and capture
// Assumes: synchronous inputs
// Notes:   output enable high while this end drives the lane
`timescale 1ns/1ps
`default_nettype none
module lane_driver #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         reset_i,
    // control
    input  wire logic         drive_i,
    input  wire logic         load_i,
    input  wire logic         capture_i,
    input  wire logic [W-1:0] wdata_i,
    // pins
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o,
    output logic              pin_oe_o,
    // captured read data
    output logic      [W-1:0] rdata_o
);

    logic [W-1:0] out_q, out_d, rd_q, rd_d;
    logic         oe_q, oe_d;

    // ----------------------------------------
    // lane next state
    // ----------------------------------------
    always_comb begin
        out_d = load_i ? wdata_i : out_q;
        rd_d  = capture_i ? pin_i : rd_q;
        oe_d  = drive_i;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            out_q <= '0;
            rd_q  <= '0;
            oe_q  <= 1'b0;
        end else begin
            out_q <= out_d;
            rd_q  <= rd_d;
            oe_q  <= oe_d;
        end
    end

    assign pin_o    = out_q;
    assign pin_oe_o = oe_q;
    assign rdata_o  = rd_q;

endmodule : lane_driver
`default_nettype wire

// ===== rtl/sram_host.sv
// Purpose: host controller driving an asynchronous static memory
// Assumes: one request at a time; pins sampled on clock_i
// Notes:   writes are strobe controlled; selects drop between cycles
`timescale 1ns/1ps
`default_nettype none
module sram_host #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          reset_i,
    // user request
    input  wire logic          req_i,
    input  wire logic          req_write_i,
    input  wire logic [AW-1:0] req_addr_i,
    input  wire logic [DW-1:0] req_wdata_i,
    input  wire logic [1:0]    req_lanes_i,
    input  wire logic          word_mode_i,
    output logic               req_ready_o,
    output logic               rsp_valid_o,
    output logic [DW-1:0]      rsp_rdata_o,
    output logic               rsp_err_o,
    output logic               rsp_err_valid_o,
    // memory control pins
    output logic [AW-1:0]      addr_o,
    output logic               select_active_low_o,
    output logic               select_active_high_o,
    output logic               write_strobe_n_o,
    output logic               output_gate_n_o,
    output logic               upper_lane_en_n_o,
    output logic               lower_lane_en_n_o,
    output logic               width_select_o,
    // memory data pins
    input  wire logic [DW-1:0] data_i,
    output logic      [DW-1:0] data_o,
    output logic      [DW-1:0] data_oe_o,
    // error flag pin, undriven sampled as not valid
    input  wire logic          err_flag_i,
    input  wire logic          err_flag_oe_i
);

    localparam int HW = DW / 2;

    sram_host_pkg::seq_state_t state_q, state_d;
    logic [sram_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [AW-1:0] addr_q, addr_d;
    logic          sel_q, sel_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
    logic [1:0]    lane_n_q, lane_n_d;
    logic          wsel_q, wsel_d;
    logic          ready_q, ready_d, valid_q, valid_d;
    logic          err_q, err_d, errv_q, errv_d;
    logic [1:0]    drive_lane, cap_lane;
    logic          load;
    logic [DW-1:0] rdata_raw, wdata_mux;
    logic [1:0]    oe_lane;

    // ----------------------------------------
    // sequencer next state
    // ----------------------------------------
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        addr_d   = addr_q;
        sel_d    = sel_q;
        we_n_d   = we_n_q;
        oe_n_d   = oe_n_q;
        lane_n_d = lane_n_q;
        wsel_d   = wsel_q;
        ready_d  = 1'b0;
        valid_d  = 1'b0;
        err_d    = err_q;
        errv_d   = 1'b0;
        load     = 1'b0;
        drive_lane = 2'b00;
        cap_lane   = 2'b00;
        case (state_q)
            sram_host_pkg::ST_IDLE: begin
                ready_d = 1'b1;
                if (req_i && ready_q) begin
                    // address and lanes set with the select, never after
                    addr_d   = req_addr_i;
                    sel_d    = 1'b1;
                    wsel_d   = word_mode_i;
                    // byte mode uses lower lane only, enables kept on
                    lane_n_d = word_mode_i ? ~req_lanes_i : 2'b00;
                    ready_d  = 1'b0;
                    load     = req_write_i;
                    cnt_d    = '0;
                    if (req_write_i) begin
                        // gate high first so the memory floats the bus
                        oe_n_d  = 1'b1;
                        we_n_d  = 1'b0;
                        state_d = sram_host_pkg::ST_WR_FLOAT;
                    end else begin
                        oe_n_d  = 1'b0;
                        we_n_d  = 1'b1;
                        state_d = sram_host_pkg::ST_RD_ACCESS;
                    end
                end
            end
            sram_host_pkg::ST_RD_ACCESS: begin
                cnt_d = cnt_q + 1'b1;
                if (32'(cnt_q) + 1 >= sram_host_pkg::ACCESS_CYC) begin
                    cap_lane = 2'b11;
                    sel_d    = 1'b0;
                    oe_n_d   = 1'b1;
                    lane_n_d = 2'b11;
                    valid_d  = 1'b1;
                    err_d    = err_flag_oe_i & err_flag_i;
                    errv_d   = err_flag_oe_i;
                    state_d  = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_WR_FLOAT: begin
                // lane enable is registered, so asking here drives one cycle
                // after the strobe fell: the memory's float time is met
                drive_lane = wsel_q ? ~lane_n_q : 2'b01;
                cnt_d = cnt_q + 1'b1;
                if (32'(cnt_q) + 1 >= sram_host_pkg::WFLOAT_CYC) begin
                    cnt_d   = '0;
                    state_d = sram_host_pkg::ST_WR_DRIVE;
                end
            end
            sram_host_pkg::ST_WR_DRIVE: begin
                // drive only enabled lanes; the other lane stays untouched
                drive_lane = wsel_q ? ~lane_n_q : 2'b01;
                cnt_d = cnt_q + 1'b1;
                if (32'(cnt_q) + 1 >= sram_host_pkg::WSETUP_CYC) begin
                    we_n_d  = 1'b1;
                    state_d = sram_host_pkg::ST_WR_END;
                end
            end
            sram_host_pkg::ST_WR_END: begin
                // data still driven at the strobe edge, released with the selects
                sel_d    = 1'b0;
                lane_n_d = 2'b11;
                valid_d  = 1'b1;
                state_d  = sram_host_pkg::ST_IDLE;
            end
            default: begin
                state_d = sram_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q  <= sram_host_pkg::ST_IDLE;
            cnt_q    <= '0;
            addr_q   <= '0;
            sel_q    <= 1'b0;
            we_n_q   <= 1'b1;
            oe_n_q   <= 1'b1;
            lane_n_q <= 2'b11;
            wsel_q   <= 1'b1;
            ready_q  <= 1'b0;
            valid_q  <= 1'b0;
            err_q    <= 1'b0;
            errv_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            addr_q   <= addr_d;
            sel_q    <= sel_d;
            we_n_q   <= we_n_d;
            oe_n_q   <= oe_n_d;
            lane_n_q <= lane_n_d;
            wsel_q   <= wsel_d;
            ready_q  <= ready_d;
            valid_q  <= valid_d;
            err_q    <= err_d;
            errv_q   <= errv_d;
        end
    end

    // ----------------------------------------
    // byte lanes
    // ----------------------------------------
    // byte mode puts the low byte of the request on lines 0 to 7
    assign wdata_mux = word_mode_i ? req_wdata_i : {req_wdata_i[HW-1:0], req_wdata_i[HW-1:0]};

    lane_driver #(.W(HW)) u_lane_lo (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .drive_i  (drive_lane[0]),
        .load_i   (load),
        .capture_i(cap_lane[0]),
        .wdata_i  (wdata_mux[HW-1:0]),
        .pin_i    (data_i[HW-1:0]),
        .pin_o    (data_o[HW-1:0]),
        .pin_oe_o (oe_lane[0]),
        .rdata_o  (rdata_raw[HW-1:0])
    );

    lane_driver #(.W(HW)) u_lane_hi (
        .clock_i  (clock_i),
        .reset_i  (reset_i),
        .drive_i  (drive_lane[1]),
        .load_i   (load),
        .capture_i(cap_lane[1]),
        .wdata_i  (wdata_mux[DW-1:HW]),
        .pin_i    (data_i[DW-1:HW]),
        .pin_o    (data_o[DW-1:HW]),
        .pin_oe_o (oe_lane[1]),
        .rdata_o  (rdata_raw[DW-1:HW])
    );

    // ----------------------------------------
    // pin and response outputs
    // ----------------------------------------
    // masking of floated lanes left to the user, lanes come raw
    assign data_oe_o            = {{HW{oe_lane[1]}}, {HW{oe_lane[0]}}};
    assign addr_o               = addr_q;
    assign select_active_low_o  = ~sel_q;
    assign select_active_high_o = sel_q;
    assign write_strobe_n_o     = we_n_q;
    assign output_gate_n_o      = oe_n_q;
    assign upper_lane_en_n_o    = lane_n_q[1];
    assign lower_lane_en_n_o    = lane_n_q[0];
    assign width_select_o       = wsel_q;
    assign req_ready_o          = ready_q;
    assign rsp_valid_o          = valid_q;
    assign rsp_rdata_o          = rdata_raw;
    assign rsp_err_o            = err_q;
    assign rsp_err_valid_o      = errv_q;

endmodule : sram_host
`default_nettype wire

// ===== dv/sram_host_assertions.sv
// Purpose: pin-level checks on the static memory host
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into sram_host, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module sram_host_checker #(
    parameter int AW = 20,
    parameter int DW = 16
) (
    // clock, reset, request
    input wire logic          clock_i,
    input wire logic          reset_i,
    input wire logic          req_i,
    input wire logic          req_write_i,
    input wire logic          req_ready_o,
    input wire logic          rsp_valid_o,
    // memory pins
    input wire logic [AW-1:0] addr_o,
    input wire logic          select_active_low_o,
    input wire logic          select_active_high_o,
    input wire logic          write_strobe_n_o,
    input wire logic          output_gate_n_o,
    input wire logic          upper_lane_en_n_o,
    input wire logic          lower_lane_en_n_o,
    input wire logic          width_select_o,
    input wire logic [DW-1:0] data_o,
    input wire logic [DW-1:0] data_oe_o
);
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    sequence s_rd_on;
        !select_active_low_o && select_active_high_o && !output_gate_n_o && write_strobe_n_o;
    endsequence
    sequence s_wr_on;
        !select_active_low_o && select_active_high_o && !write_strobe_n_o && output_gate_n_o;
    endsequence
    property p_rd_strobe; !output_gate_n_o |-> write_strobe_n_o; endproperty
    property p_no_fight; data_oe_o != '0 |-> output_gate_n_o; endproperty
    property p_rd_walk;
        req_i && req_ready_o && !req_write_i |=> s_rd_on ##1 output_gate_n_o ##[0:1] rsp_valid_o;
    endproperty
    property p_wr_walk;
        req_i && req_ready_o && req_write_i |=> s_wr_on ##1 (s_wr_on and data_oe_o != '0)
            ##1 write_strobe_n_o ##[0:1] rsp_valid_o;
    endproperty
    property p_wr_end;
        $rose(write_strobe_n_o) |-> $past(data_oe_o) != '0 && data_oe_o != '0 && $stable(data_o);
    endproperty
    property p_addr_hold;
        !select_active_low_o && !$past(select_active_low_o) |-> $stable(addr_o);
    endproperty
    property p_width_hold;
        !select_active_low_o && !$past(select_active_low_o) |-> $stable(width_select_o);
    endproperty
    property p_lane_lo; data_oe_o[DW/2-1:0] != '0 |-> !lower_lane_en_n_o; endproperty
    property p_lane_hi;
        data_oe_o[DW-1:DW/2] != '0 |-> !upper_lane_en_n_o && width_select_o;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read");
    a_no_fight: assert property (p_no_fight) else $error("drive with gate low");
    a_rd_walk: assert property (p_rd_walk) else $error("read sequence wrong");
    a_wr_walk: assert property (p_wr_walk) else $error("write sequence wrong");
    a_wr_end: assert property (p_wr_end) else $error("data not held at end");
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    a_width_hold: assert property (p_width_hold) else $error("width moved");
    a_lane_lo: assert property (p_lane_lo) else $error("lower lane off");
    a_lane_hi: assert property (p_lane_hi) else $error("upper lane off");
endmodule : sram_host_checker
bind sram_host sram_host_checker #(.AW(AW), .DW(DW)) sram_host_checker_inst (
    .clock_i(clock_i), .reset_i(reset_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .addr_o(addr_o),
    .select_active_low_o(select_active_low_o), .select_active_high_o(select_active_high_o),
    .write_strobe_n_o(write_strobe_n_o), .output_gate_n_o(output_gate_n_o),
    .upper_lane_en_n_o(upper_lane_en_n_o), .lower_lane_en_n_o(lower_lane_en_n_o),
    .width_select_o(width_select_o), .data_o(data_o), .data_oe_o(data_oe_o)
);
`default_nettype wire

// ===== dv/sram_device_model.sv
// Purpose: behavioural static memory on the far side of the host
// Assumes: small arrays, low address bits only
// Notes:   writes land when the write overlap ends
`timescale 1ns/1ps
`default_nettype none
module sram_device_model (
    // host pins
    input  wire logic [19:0] addr_i,
    input  wire logic        sel_n_i,
    input  wire logic        sel_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        up_n_i,
    input  wire logic        lo_n_i,
    input  wire logic        wide_i,
    input  wire logic [15:0] bus_i,
    input  wire logic        inject_err_i,
    // device outputs
    output logic      [15:0] mem_data_o,
    output logic      [15:0] mem_oe_o,
    output logic             err_o,
    output logic             err_oe_o
);
    logic       on, rd, wr, bm;
    logic [15:0] wmem [0:255];
    logic [7:0]  bmem [0:511];
    // decode; both lanes off is standby in word mode, byte mode ignores the lane enables
    assign on = !sel_n_i && sel_i;
    assign bm = !wide_i;
    assign rd = on && we_n_i && !oe_n_i && (bm || !(up_n_i && lo_n_i));
    assign wr = on && !we_n_i && (bm || !(up_n_i && lo_n_i));
    // drive only enabled lanes while reading in word mode, the lower lane only in byte mode
    always_comb begin
        mem_data_o = bm ? {8'h00, bmem[addr_i[8:0]]} : wmem[addr_i[7:0]];
        mem_oe_o = {{8{rd && !bm && !up_n_i}}, {8{rd && (bm || !lo_n_i)}}};
        err_oe_o = rd;
        err_o = inject_err_i;
    end
    // commit at the end of the overlap, data sampled there
    always @(negedge wr) begin
        if (on === 1'b1 && bm) bmem[addr_i[8:0]] = bus_i[7:0];
        else if (on === 1'b1) begin
            if (!lo_n_i) wmem[addr_i[7:0]][7:0] = bus_i[7:0];
            if (!up_n_i) wmem[addr_i[7:0]][15:8] = bus_i[15:8];
        end
    end
endmodule : sram_device_model
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench for the static memory host
// Assumes: device model on the pins, 50 ns clock
// Notes:   floating lines show a pattern that moves every cycle
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module testbench;
    logic clock_i, reset_i, req_i, req_write_i, word_mode_i, req_ready_o, rsp_valid_o;
    logic rsp_err_o, rsp_err_valid_o, sn, sp, we_n, oe_n, up_n, lo_n, wide, inject;
    logic ef, ef_oe;
    logic [19:0] req_addr_i, addr;
    logic [15:0] req_wdata_i, rsp_rdata_o, data_o, data_oe_o, md, moe, bus;
    logic [1:0]  req_lanes_i;
    int          num_errors = 0, tests_run = 0, cycles = 0;
    // resolved data bus, released lines get a moving pattern
    assign bus = (data_oe_o & data_o) | (~data_oe_o & moe & md) | (~data_oe_o & ~moe & ~cycles[15:0]);
    sram_host sram_host_inst (.clock_i(clock_i), .reset_i(reset_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_lanes_i(req_lanes_i), .word_mode_i(word_mode_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_err_o(rsp_err_o),
        .rsp_err_valid_o(rsp_err_valid_o), .addr_o(addr), .select_active_low_o(sn),
        .select_active_high_o(sp), .write_strobe_n_o(we_n), .output_gate_n_o(oe_n),
        .upper_lane_en_n_o(up_n), .lower_lane_en_n_o(lo_n), .width_select_o(wide),
        .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
        .err_flag_i(ef_oe ? ef : cycles[0]), .err_flag_oe_i(ef_oe));
    sram_device_model sram_device_model_inst (.addr_i(addr), .sel_n_i(sn), .sel_i(sp),
        .we_n_i(we_n), .oe_n_i(oe_n), .up_n_i(up_n), .lo_n_i(lo_n), .wide_i(wide),
        .bus_i(bus), .inject_err_i(inject), .mem_data_o(md), .mem_oe_o(moe),
        .err_o(ef), .err_oe_o(ef_oe));
    // one access: wait ready, present request, wait answer
    task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d,
                       input logic [1:0] ln, input logic wm);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20) begin @(posedge clock_i); #1; n++; end
        {req_i, req_write_i, req_addr_i, req_wdata_i, req_lanes_i, word_mode_i} = {1'b1, w, a, d, ln, wm};
        @(posedge clock_i); #1;
        req_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 20) begin @(posedge clock_i); #1; n++; end
        `CHK(rsp_valid_o, 1'b1)
    endtask : acc
    task automatic t_word();
        acc(1, 20'h0_0005, 16'hA5C3, 2'b11, 1); acc(0, 20'h0_0005, 16'h0000, 2'b11, 1);
        `CHK(rsp_rdata_o, 16'hA5C3)
        $display("test word done");
    endtask : t_word
    task automatic t_lanes();
        acc(1, 20'h0_0005, 16'h0011, 2'b01, 1); acc(1, 20'h0_0005, 16'h7700, 2'b10, 1);
        acc(0, 20'h0_0005, 16'h0000, 2'b11, 1);
        `CHK(rsp_rdata_o, 16'h7711)
        acc(0, 20'h0_0005, 16'h0000, 2'b10, 1);
        `CHK(rsp_rdata_o[15:8], 8'h77)
        acc(0, 20'h0_0005, 16'h0000, 2'b01, 1);
        `CHK(rsp_rdata_o[7:0], 8'h11)
        $display("test lanes done");
    endtask : t_lanes
    task automatic t_byte();
        acc(1, 20'h0_0003, 16'h005A, 2'b11, 0); acc(1, 20'h0_0002, 16'h00C6, 2'b11, 0);
        acc(0, 20'h0_0003, 16'h0000, 2'b11, 0);
        `CHK(rsp_rdata_o[7:0], 8'h5A)
        acc(0, 20'h0_0002, 16'h0000, 2'b11, 0);
        `CHK(rsp_rdata_o[7:0], 8'hC6)
        $display("test byte done");
    endtask : t_byte
    task automatic t_err();
        inject = 1'b1;
        acc(0, 20'h0_0005, 16'h0000, 2'b11, 1);
        `CHK({rsp_err_valid_o, rsp_err_o}, 2'b11)
        acc(1, 20'h0_0006, 16'h1234, 2'b11, 1);
        `CHK(rsp_err_valid_o, 1'b0)
        inject = 1'b0;
        acc(0, 20'h0_0005, 16'h0000, 2'b11, 1);
        `CHK({rsp_err_valid_o, rsp_err_o}, 2'b10)
        $display("test err done");
    endtask : t_err
    task automatic summarize();
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // clock and hang guard
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin num_errors++; $display("Error %0t: timeout", $time); summarize(); end
    end
    initial begin
        {reset_i, req_i, req_write_i, word_mode_i, inject} = 5'b1_0010;
        {req_addr_i, req_wdata_i, req_lanes_i} = '0;
        repeat (3) @(posedge clock_i);
        #1 reset_i = 1'b0;
        `CHK({sn, sp, we_n, oe_n, data_oe_o}, {4'b1011, 16'h0000})
        t_word(); t_lanes(); t_byte(); t_err();
        summarize();
    end
endmodule : testbench
`default_nettype wire
